// file: verilog/liu_pkg.sv
/*
 * Shared constants of the parallel host port: pin widths, layout of the
 * synchronised pin vectors, register defaults and handshake timing.
 * Assumes a 100 MHz reference clock on both ends of the port.
 */
`default_nettype none

package liu_pkg;

	// ************************************************************
	// Bus widths
	// ************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// ************************************************************
	// Layout of the device's synchronised input vector
	// ************************************************************
	localparam int DEV_PIN_W = 21;
	localparam int DEV_PCLK_BIT = 20;
	localparam int DEV_PMODE_BIT = 19;
	localparam int DEV_CS_BIT = 18;
	localparam int DEV_RD_BIT = 17;
	localparam int DEV_WR_BIT = 16;
	localparam int DEV_ADDR_LSB = 8;
	localparam int DEV_DATA_LSB = 0;

	// ************************************************************
	// Layout of the host's synchronised input vector
	// ************************************************************
	localparam int HOST_PIN_W = 10;
	localparam int HOST_RDY_BIT = 9;
	localparam int HOST_INT_BIT = 8;
	localparam int HOST_DATA_LSB = 0;

	// ************************************************************
	// Register defaults and fixed locations
	// ************************************************************
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] ALARM_STAT_ADDR = 8'h03;
	localparam logic [7:0] ALARM_RESET = 8'h00;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int PCLK_MIN_PERIOD_NS = 15;
	localparam int ASYNC_STROBE_MIN_NS = 70;
	localparam int SYNC_STROBE_MIN_NS = 40;
	localparam int ASYNC_STROBE_MIN_CYC = (ASYNC_STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_STROBE_MIN_CYC = (SYNC_STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// file: verilog/liu_if.sv
/*
 * Pin-level carrier between the host end and the device end of the port.
 * Assumes the testbench drives nothing on the data wires; the shared data
 * bus is resolved here from the two output enables.
 */
`timescale 1ns/100ps
`default_nettype none

interface liu_if;
	// Mode and host clock
	logic pmode;
	logic pclk;
	// Access control
	logic [7:0] addr;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic rdy_n;
	logic int_n;
	// Data bus halves
	logic [7:0] host_d_out;
	logic host_d_oe;
	logic [7:0] dev_d_out;
	logic dev_d_oe;
	wire [7:0] d;

	// Resolve the shared data wires; an undriven bus reads as its pull-up level
	assign d = dev_d_oe ? dev_d_out : (host_d_oe ? host_d_out : 8'hff);

	modport device (
		input pmode, pclk, addr, cs_n, rd_n, wr_n, d,
		output rdy_n, int_n, dev_d_out, dev_d_oe
	);

	modport host (
		input rdy_n, int_n, d,
		output pmode, pclk, addr, cs_n, rd_n, wr_n, host_d_out, host_d_oe
	);
endinterface

`default_nettype wire

// file: verilog/liu_device_port.sv
/*
 * Device end of the parallel host port: pin synchronisers, read/write
 * handshake in asynchronous or synchronous timing, a flip-flop register
 * bank and a cleared-on-read alarm status register behind the interrupt.
 * Assumes the host keeps the bus protocol; all pins arrive from outside the
 * ref_clk domain and pass a three-stage synchroniser.
 */
`timescale 1ns/100ps
`default_nettype none

// Function
// (RULE_01) Sample timing select to pick the mode
// (RULE_02) Low asynchronous, high synchronous timing
// (RULE_03) Synchronous mode times handshake from host clock
// (RULE_04) Same read and write sequence in both modes
// (RULE_05) Eight-bit address selects one register directly
// (RULE_06) Accept accesses only while chip select low
// (RULE_07) Host sets address before chip select falls
// (RULE_08) Read strobe fall under select starts read
// (RULE_09) Read drives selected register onto data bus
// (RULE_10) Ready goes low once read data valid
// (RULE_11) Host ends read after ready and capture
// (RULE_12) Host puts write data before store strobe
// (RULE_13) Store strobe fall starts write, bus input
// (RULE_14) Ready goes low once write data stored
// (RULE_15) Ready low means cycle complete, next accepted
// (RULE_16) Host raises chip select between commands
// (RULE_17) Sync ready within two host clocks plus 5ns
// (RULE_18) Alarm change drives interrupt output low
// (RULE_19) Interrupt released once alarm status read clear
// (RULE_20) Low reset input resets the port logic
// (RULE_21) Reset release loads every register default
// (RULE_22) Strobe or select high releases ready, bus
// (RULE_23) Strobes ignored, bus undriven while deselected
module liu_device_port #(
	parameter int NUM_REGS = 256
) (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	// Pin side
	liu_if.device bus,
	// Alarm events from the line functions
	input wire logic [7:0] alarm_set,
	// User view of the register bank
	input wire logic [7:0] user_addr,
	output logic [7:0] user_rdata,
	output logic sync_mode
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (NUM_REGS < 1 || NUM_REGS > 256) begin : g_bad_regs
		$error("NUM_REGS must lie between 1 and 256");
	end

	// ************************************************************
	// State
	// ************************************************************
	typedef enum logic [1:0] {
		DEV_IDLE,
		DEV_WAIT,
		DEV_DONE
	} dev_state_t;

	typedef struct packed {
		logic [liu_pkg::DEV_PIN_W-1:0] s1;
		logic [liu_pkg::DEV_PIN_W-1:0] s2;
		logic [liu_pkg::DEV_PIN_W-1:0] s3;
		logic [liu_pkg::DEV_PIN_W-1:0] f;
		logic [liu_pkg::DEV_PIN_W-1:0] fp;
		dev_state_t st;
		logic is_rd;
		logic sync_mode;
		logic [7:0] dout;
		logic doe;
		logic rdy_n;
		logic int_n;
		logic [7:0] alarm;
		logic [7:0] user_rdata;
		logic [NUM_REGS-1:0][7:0] regs;
	} dev_t;

	dev_t s_reg;
	dev_t s_next;

	logic [liu_pkg::DEV_PIN_W-1:0] pins;
	logic [liu_pkg::DEV_PIN_W-1:0] diff;
	logic [7:0] a;
	logic [7:0] wd;
	logic cs_low;
	logic rd_fall;
	logic wr_fall;
	logic pclk_rise;
	logic strobe_hi;
	logic alarm_clr;

	// Gather raw pins into one vector for the synchroniser
	assign pins = {bus.pclk, bus.pmode, bus.cs_n, bus.rd_n, bus.wr_n, bus.addr, bus.d};

	// Filtered pin decodes
	assign diff = s_reg.s2 ^ s_reg.s3;
	assign a = s_reg.f[liu_pkg::DEV_ADDR_LSB +: 8];
	assign wd = s_reg.f[liu_pkg::DEV_DATA_LSB +: 8];
	assign cs_low = ~s_reg.f[liu_pkg::DEV_CS_BIT];
	assign rd_fall = s_reg.fp[liu_pkg::DEV_RD_BIT] & ~s_reg.f[liu_pkg::DEV_RD_BIT];
	assign wr_fall = s_reg.fp[liu_pkg::DEV_WR_BIT] & ~s_reg.f[liu_pkg::DEV_WR_BIT];
	assign pclk_rise = ~s_reg.fp[liu_pkg::DEV_PCLK_BIT] & s_reg.f[liu_pkg::DEV_PCLK_BIT];
	assign strobe_hi = s_reg.is_rd ? s_reg.f[liu_pkg::DEV_RD_BIT] : s_reg.f[liu_pkg::DEV_WR_BIT];

	// Register bank read with unmapped addresses returning zero
	function automatic logic [7:0] bank_read(input dev_t s, input logic [7:0] ad);
		logic [7:0] r;
		r = 8'h00;
		if (ad == liu_pkg::ALARM_STAT_ADDR) begin
			r = s.alarm;
		end else if (int'(ad) < NUM_REGS) begin
			r = s.regs[ad];
		end
		return r;
	endfunction

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		s_next = s_reg;
		alarm_clr = 1'b0;
		// Three-stage synchroniser, a change counts when stages two and three agree
		s_next.s1 = pins;
		s_next.s2 = s_reg.s1;
		s_next.s3 = s_reg.s2;
		s_next.f = (s_reg.s2 & ~diff) | (s_reg.f & diff);
		s_next.fp = s_reg.f;
		s_next.user_rdata = bank_read(s_reg, user_addr);

		case (s_reg.st)
			DEV_IDLE: begin
				s_next.doe = 1'b0;
				s_next.rdy_n = 1'b1;
				// Mode pin is taken afresh before each access
				s_next.sync_mode = s_reg.f[liu_pkg::DEV_PMODE_BIT]; // [RULE_01] [RULE_02]
				if (cs_low && rd_fall) begin // [RULE_06] [RULE_08] [RULE_23]
					s_next.is_rd = 1'b1;
					s_next.dout = bank_read(s_reg, a); // [RULE_05] [RULE_09]
					s_next.doe = 1'b1; // [RULE_09]
					alarm_clr = (a == liu_pkg::ALARM_STAT_ADDR); // [RULE_19]
					s_next.st = DEV_WAIT;
				end else if (cs_low && wr_fall) begin // [RULE_06] [RULE_13] [RULE_23]
					s_next.is_rd = 1'b0;
					if (int'(a) < NUM_REGS && a != liu_pkg::ALARM_STAT_ADDR) begin
						s_next.regs[a] = wd; // [RULE_05] [RULE_14]
					end
					s_next.st = DEV_WAIT;
				end
			end
			DEV_WAIT: begin
				// Both modes run the same sequence, only the time that ready goes low differs
				if (!cs_low || strobe_hi) begin // [RULE_22]
					s_next.doe = 1'b0;
					s_next.st = DEV_IDLE;
				end else if (!s_reg.sync_mode || pclk_rise) begin // [RULE_03] [RULE_04] [RULE_17]
					s_next.rdy_n = 1'b0; // [RULE_10] [RULE_14] [RULE_15]
					s_next.st = DEV_DONE;
				end
			end
			DEV_DONE: begin
				if (!cs_low || strobe_hi) begin // [RULE_22]
					s_next.rdy_n = 1'b1;
					s_next.doe = 1'b0;
					s_next.st = DEV_IDLE;
				end
			end
			default: begin
				s_next.st = DEV_IDLE;
			end
		endcase

		// Alarm bits are sticky, a new event wins over the clearing read
		s_next.alarm = (alarm_clr ? 8'h00 : s_reg.alarm) | alarm_set; // [RULE_19]
		s_next.int_n = ~|s_next.alarm; // [RULE_18] [RULE_19]
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin // [RULE_20] [RULE_21]
			// History starts at the idle pin level so release shows no false strobe edge
			s_reg.s1 <= '1;
			s_reg.s2 <= '1;
			s_reg.s3 <= '1;
			s_reg.f <= '1;
			s_reg.fp <= '1;
			s_reg.st <= DEV_IDLE;
			s_reg.is_rd <= 1'b0;
			s_reg.sync_mode <= 1'b0;
			s_reg.dout <= 8'h00;
			s_reg.doe <= 1'b0;
			s_reg.rdy_n <= 1'b1;
			s_reg.int_n <= 1'b1;
			s_reg.alarm <= liu_pkg::ALARM_RESET;
			s_reg.user_rdata <= 8'h00;
			s_reg.regs <= {NUM_REGS{liu_pkg::REG_RESET}};
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from flip-flops
	assign bus.dev_d_out = s_reg.dout;
	assign bus.dev_d_oe = s_reg.doe;
	assign bus.rdy_n = s_reg.rdy_n;
	assign bus.int_n = s_reg.int_n;
	assign user_rdata = s_reg.user_rdata;
	assign sync_mode = s_reg.sync_mode;

endmodule // liu_device_port

`default_nettype wire

// file: verilog/liu_host_port.sv
/*
 * Host end of the parallel port: turns single-word requests into a
 * chip-select / strobe / ready handshake and makes the host bus clock.
 * Assumes the device keeps its handshake; ready, interrupt and data come
 * from outside the ref_clk domain and pass a three-stage synchroniser.
 */
`timescale 1ns/100ps
`default_nettype none

module liu_host_port #(
	parameter int PCLK_HALF_CYC = 1
) (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	// Pin side
	liu_if.host bus,
	// Mode request
	input wire logic sync_sel,
	// Request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [7:0] req_addr,
	input wire logic [7:0] req_wdata,
	// Answer
	output logic resp_valid,
	output logic [7:0] resp_rdata,
	output logic irq
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (PCLK_HALF_CYC < 1 || PCLK_HALF_CYC > 255 ||
		2 * PCLK_HALF_CYC * liu_pkg::CLK_PERIOD_NS < liu_pkg::PCLK_MIN_PERIOD_NS) begin : g_bad_pclk
		$error("PCLK_HALF_CYC gives a host clock outside its limits");
	end

	// ************************************************************
	// State
	// ************************************************************
	typedef enum logic [2:0] {
		H_IDLE,
		H_ADDR,
		H_SELECT,
		H_STROBE,
		H_RELEASE
	} host_state_t;

	typedef struct packed {
		logic [liu_pkg::HOST_PIN_W-1:0] s1;
		logic [liu_pkg::HOST_PIN_W-1:0] s2;
		logic [liu_pkg::HOST_PIN_W-1:0] s3;
		logic [liu_pkg::HOST_PIN_W-1:0] f;
		host_state_t st;
		logic [7:0] div;
		logic pclk;
		logic pmode;
		logic wr;
		logic [7:0] addr;
		logic [7:0] dout;
		logic doe;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [7:0] cnt;
		logic resp_valid;
		logic [7:0] rdata;
		logic irq;
	} host_t;

	host_t s_reg;
	host_t s_next;

	logic [liu_pkg::HOST_PIN_W-1:0] pins;
	logic [liu_pkg::HOST_PIN_W-1:0] diff;
	logic [7:0] min_cyc;
	logic rdy_low;

	assign pins = {bus.rdy_n, bus.int_n, bus.d};
	assign diff = s_reg.s2 ^ s_reg.s3;
	assign rdy_low = ~s_reg.f[liu_pkg::HOST_RDY_BIT];
	// Least strobe width for the mode in use
	assign min_cyc = s_reg.pmode ? 8'(liu_pkg::SYNC_STROBE_MIN_CYC) : 8'(liu_pkg::ASYNC_STROBE_MIN_CYC);
	// New work is taken only when the port is idle
	assign req_ready = (s_reg.st == H_IDLE);

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		s_next = s_reg;
		s_next.resp_valid = 1'b0;
		// Three-stage synchroniser with agreement filter
		s_next.s1 = pins;
		s_next.s2 = s_reg.s1;
		s_next.s3 = s_reg.s2;
		s_next.f = (s_reg.s2 & ~diff) | (s_reg.f & diff);
		s_next.irq = ~s_reg.f[liu_pkg::HOST_INT_BIT];
		// Host bus clock from a divider
		if (s_reg.div == 8'(PCLK_HALF_CYC - 1)) begin
			s_next.div = 8'h00;
			s_next.pclk = ~s_reg.pclk;
		end else begin
			s_next.div = s_reg.div + 8'h01;
		end

		case (s_reg.st)
			H_IDLE: begin
				s_next.pmode = sync_sel; // [RULE_02]
				if (req_valid) begin
					s_next.wr = req_write;
					s_next.addr = req_addr; // [RULE_07]
					s_next.dout = req_wdata;
					s_next.st = H_ADDR;
				end
			end
			H_ADDR: begin
				// Address is already stable when select falls
				s_next.cs_n = 1'b0; // [RULE_07]
				s_next.doe = s_reg.wr; // [RULE_12]
				s_next.st = H_SELECT;
			end
			H_SELECT: begin
				s_next.rd_n = s_reg.wr;
				s_next.wr_n = ~s_reg.wr; // [RULE_12]
				s_next.cnt = 8'h01;
				s_next.st = H_STROBE;
			end
			H_STROBE: begin
				if (s_reg.cnt != 8'hff) begin
					s_next.cnt = s_reg.cnt + 8'h01;
				end
				if (rdy_low && s_reg.cnt >= min_cyc) begin // [RULE_11]
					s_next.rdata = s_reg.f[liu_pkg::HOST_DATA_LSB +: 8];
					s_next.rd_n = 1'b1;
					s_next.wr_n = 1'b1;
					s_next.cs_n = 1'b1; // [RULE_16]
					s_next.doe = 1'b0;
					s_next.st = H_RELEASE;
				end
			end
			H_RELEASE: begin
				// Wait for ready to go back high before the next command
				if (!rdy_low) begin
					s_next.resp_valid = 1'b1;
					s_next.st = H_IDLE;
				end
			end
			default: begin
				s_next.st = H_IDLE;
			end
		endcase
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_reg.s1 <= '1;
			s_reg.s2 <= '1;
			s_reg.s3 <= '1;
			s_reg.f <= '1;
			s_reg.st <= H_IDLE;
			s_reg.div <= 8'h00;
			s_reg.pclk <= 1'b0;
			s_reg.pmode <= 1'b0;
			s_reg.wr <= 1'b0;
			s_reg.addr <= 8'h00;
			s_reg.dout <= 8'h00;
			s_reg.doe <= 1'b0;
			s_reg.cs_n <= 1'b1;
			s_reg.rd_n <= 1'b1;
			s_reg.wr_n <= 1'b1;
			s_reg.cnt <= 8'h00;
			s_reg.resp_valid <= 1'b0;
			s_reg.rdata <= 8'h00;
			s_reg.irq <= 1'b0;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// Outputs from flip-flops
	assign bus.pmode = s_reg.pmode;
	assign bus.pclk = s_reg.pclk;
	assign bus.addr = s_reg.addr;
	assign bus.cs_n = s_reg.cs_n;
	assign bus.rd_n = s_reg.rd_n;
	assign bus.wr_n = s_reg.wr_n;
	assign bus.host_d_out = s_reg.dout;
	assign bus.host_d_oe = s_reg.doe;
	assign resp_valid = s_reg.resp_valid;
	assign resp_rdata = s_reg.rdata;
	assign irq = s_reg.irq;

endmodule // liu_host_port

`default_nettype wire

// file: tb/liu_checker.sv
/*
 * Pin-side assertions for the parallel host port.
 * Assumes it sits beside the interface that joins the host and device ends.
 */
`timescale 1ns/100ps
`default_nettype none

module liu_checker #(
	parameter int PCLK_HALF_CYC = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Port pins
	input wire logic pmode,
	input wire logic [7:0] addr,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic rdy_n,
	input wire logic int_n,
	input wire logic host_d_oe,
	input wire logic dev_d_oe
);
	// Two host clocks plus 5 ns, rounded up, plus pin filter slack
	localparam int SYNC_MAX = 4 * PCLK_HALF_CYC + 4;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	// ************************************************************
	// Handshake
	// ************************************************************
	sel_gates_ready_a: assert property ($fell(rdy_n) |-> !cs_n && !(rd_n && wr_n))
		else $error("ready without selected strobe");
	read_drives_bus_a: assert property (!rdy_n && !rd_n |-> dev_d_oe)
		else $error("read data not driven");
	write_bus_input_a: assert property (!wr_n |-> !dev_d_oe)
		else $error("device drives bus in write");
	async_ready_a: assert property ($fell(rd_n && wr_n) && !pmode |-> ##[1:8] !rdy_n)
		else $error("async ready late");
	sync_ready_a: assert property ($fell(rd_n && wr_n) && pmode |-> ##[1:SYNC_MAX] !rdy_n)
		else $error("sync ready late");
	release_ready_a: assert property ($rose(rd_n) || $rose(cs_n) |-> ##[1:8] rdy_n && !dev_d_oe)
		else $error("ready or bus not released");
	idle_quiet_a: assert property (cs_n [*8] |-> rdy_n && !dev_d_oe)
		else $error("activity while deselected");
	reset_idle_a: assert property ($rose(nrst) |-> rdy_n && int_n && !dev_d_oe)
		else $error("outputs active at reset release");
	irq_clear_a: assert property ($rose(int_n) |-> !cs_n && addr == liu_pkg::ALARM_STAT_ADDR)
		else $error("interrupt released without status read");
	addr_stable_a: assert property (!cs_n |-> $stable(addr))
		else $error("address moved under select");
	data_first_a: assert property ($fell(wr_n) |-> $past(host_d_oe))
		else $error("write data late");
	read_end_a: assert property ($rose(rd_n) |-> $past(rdy_n) == 1'b0)
		else $error("read ended before ready");

	// Main scenarios reached
	cover property ($fell(rd_n) && !pmode);
	cover property ($fell(wr_n) && pmode);
	cover property ($rose(int_n));
endmodule // liu_checker

`default_nettype wire

// file: tb/tb_liu_parallel_host_interface.sv
/*
 * Self-checking bench: host end and device end joined by the port
 * interface, plus a second device end driven by hand for misuse.
 * Assumes the design files and the checker are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_liu_parallel_host_interface;
	localparam int H = 4;
	localparam logic [7:0] AL = liu_pkg::ALARM_STAT_ADDR;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic sync_sel = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [7:0] req_addr = 8'h00;
	logic [7:0] req_wdata = 8'h00;
	logic [7:0] alarm_set = 8'h00;
	logic [7:0] user_addr = 8'h00;
	logic req_ready, resp_valid, irq, sync_mode;
	logic [7:0] resp_rdata, user_rdata;
	logic [7:0] rnd = 8'h05;
	logic [8:0] note;
	logic [8:0] exp_q [$];
	int n_mismatch = 0;
	int check_count = 0;

	// ************************************************************
	// Design under test
	// ************************************************************
	liu_if bus ();
	liu_if bus2 ();
	liu_host_port #(.PCLK_HALF_CYC(H)) liu_host_port_i (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1), .bus(bus),
		.sync_sel(sync_sel), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata), .irq(irq));
	liu_device_port liu_device_port_i (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1), .bus(bus),
		.alarm_set(alarm_set), .user_addr(user_addr), .user_rdata(user_rdata), .sync_mode(sync_mode));
	liu_device_port liu_device_port_i2 (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1), .bus(bus2),
		.alarm_set(8'h00), .user_addr(user_addr), .user_rdata(), .sync_mode());
	liu_checker #(.PCLK_HALF_CYC(H)) liu_checker_i (.ref_clk(ref_clk), .nrst(nrst), .pmode(bus.pmode),
		.addr(bus.addr), .cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n), .rdy_n(bus.rdy_n),
		.int_n(bus.int_n), .host_d_oe(bus.host_d_oe), .dev_d_oe(bus.dev_d_oe));

	// ************************************************************
	// Helpers
	// ************************************************************
	initial forever #5 ref_clk = ~ref_clk;

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Wait n edges, then step just past the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Let every outstanding answer come back before moving on
	task automatic drain;
		for (int i = 0; i < 200 && exp_q.size() > 0; i++) cyc(1);
	endtask

	task automatic do_reset;
		nrst = 1'b0;
		cyc(5);
		nrst = 1'b1;
	endtask

	// One host request; every answer gets a note, reads carry the byte
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v, input logic [7:0] e);
		cyc(1);
		while (req_ready !== 1'b1) cyc(1);
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = v;
		exp_q.push_back({w, e});
		cyc(1);
		req_valid = 1'b0;
	endtask

	// Random writes, each read straight back, in one timing mode
	task automatic traffic(input logic mode);
		logic [7:0] a;
		sync_sel = mode;
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			a = (rnd == AL) ? 8'h04 : rnd;
			rnd = lfsr(rnd);
			user_addr = a;
			xfer(1'b1, a, rnd, 8'h00);
			xfer(1'b0, a, 8'h00, rnd);
			chk("user view", user_rdata, rnd);
		end
		chk("mode", {7'h00, sync_mode}, {7'h00, mode});
	endtask

	task automatic wait_irq(input logic lvl);
		for (int i = 0; i < 40 && irq !== lvl; i++) cyc(1);
		chk("irq", {7'h00, irq}, {7'h00, lvl});
	endtask

	// Compare each read answer with the oldest note; a spare answer meets an unknown
	always @(negedge ref_clk) begin
		if (resp_valid === 1'b1) begin
			note = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h0xx;
			if (note[8] === 1'b0) chk("read data", resp_rdata, note[7:0]);
		end
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		stop_test();
	end

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		bus2.pmode = 1'b0;
		bus2.pclk = 1'b0;
		bus2.addr = 8'h00;
		bus2.cs_n = 1'b1;
		bus2.rd_n = 1'b1;
		bus2.wr_n = 1'b1;
		bus2.host_d_out = 8'h00;
		bus2.host_d_oe = 1'b0;
		do_reset();
		// Defaults after reset
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			xfer(1'b0, rnd, 8'h00, liu_pkg::REG_RESET);
		end
		traffic(1'b0);
		traffic(1'b1);
		// Alarm raise, dropped write to status, clear by read
		alarm_set = 8'h5a;
		cyc(1);
		alarm_set = 8'h00;
		wait_irq(1'b1);
		xfer(1'b1, AL, 8'hff, 8'h00);
		xfer(1'b0, AL, 8'h00, 8'h5a);
		wait_irq(1'b0);
		xfer(1'b0, AL, 8'h00, liu_pkg::ALARM_RESET);
		drain();
		// Second reset in mid-run wipes the bank
		do_reset();
		xfer(1'b0, user_addr, 8'h00, liu_pkg::REG_RESET);
		cyc(3);
		chk("user view reset", user_rdata, liu_pkg::REG_RESET);
		// Misuse on the second port: strobe while deselected
		bus2.rd_n = 1'b0;
		cyc(12);
		chk("deselected", {6'h00, bus2.rdy_n, bus2.dev_d_oe}, 8'h02);
		bus2.rd_n = 1'b1;
		bus2.cs_n = 1'b0;
		cyc(6);
		bus2.rd_n = 1'b0;
		cyc(12);
		chk("hand read", {6'h00, bus2.rdy_n, bus2.dev_d_oe}, 8'h01);
		chk("hand data", bus2.d, liu_pkg::REG_RESET);
		// Select dropped with the strobe still low
		bus2.cs_n = 1'b1;
		cyc(10);
		chk("released", {6'h00, bus2.rdy_n, bus2.dev_d_oe}, 8'h02);
		chk("bus idle", bus2.d, 8'hff);
		drain();
		chk("notes left", 8'(exp_q.size()), 8'h00);
		stop_test();
	end
endmodule // tb_liu_parallel_host_interface

`default_nettype wire
